// >>> hdl/sbc_cfg_if.sv
// Carrier between the strap capture logic and the strap decoder.
`timescale 1ns/10ps
interface sbc_cfg_if;
    sbc_pkg::sbc_strap_type strap;
    logic ovr_ldo_en;
    logic ovr_ldo_1v8;
    logic ovr_edge_en;
    logic ovr_in_rise;
    logic ovr_out_rise;
    logic ldo_1v8;
    sbc_pkg::sbc_boot_mode_type boot_mode;
    logic log_enable;
    logic in_rise;
    logic out_rise;

    modport capture (
        output strap, ovr_ldo_en, ovr_ldo_1v8, ovr_edge_en, ovr_in_rise, ovr_out_rise,
        input ldo_1v8, boot_mode, log_enable, in_rise, out_rise
    );

    modport decoder (
        input strap, ovr_ldo_en, ovr_ldo_1v8, ovr_edge_en, ovr_in_rise, ovr_out_rise,
        output ldo_1v8, boot_mode, log_enable, in_rise, out_rise
    );
endinterface

// >>> hdl/sbc_decode.sv
// Decoder that turns captured strap bits and firmware overrides into settings.
`timescale 1ns/10ps
`include "sbc_regs.svh"
module sbc_decode (
    input wire logic aclk,
    input wire logic aresetn,
    sbc_cfg_if.decoder cfg
);

    // ----------------------------------------------------------------
    // Boot source
    // ----------------------------------------------------------------
    function automatic sbc_pkg::sbc_boot_mode_type sbc_mode(input logic sel, input logic qual);
        sbc_pkg::sbc_boot_mode_type m;
        m = sbc_pkg::SBC_BOOT_UNDEFINED;
        if (sel) begin
            m = sbc_pkg::SBC_BOOT_FLASH;
        end else if (!qual) begin
            m = sbc_pkg::SBC_BOOT_DOWNLOAD;
        end
        return m;
    endfunction

    // A high boot select wins, so the qualifier is not looked at then.
    assign cfg.boot_mode = sbc_mode(cfg.strap[`SBC_BOOT_SEL_BIT], cfg.strap[`SBC_DL_QUAL_BIT]);

    // ----------------------------------------------------------------
    // Supply, log and edge settings
    // ----------------------------------------------------------------
    wire logic strap_ldo = cfg.strap[`SBC_LDO_BIT];
    assign cfg.ldo_1v8 = cfg.ovr_ldo_en ? cfg.ovr_ldo_1v8 : strap_ldo;
    assign cfg.log_enable = cfg.strap[`SBC_LOG_EDGE_BIT];
    assign cfg.in_rise = cfg.ovr_edge_en ? cfg.ovr_in_rise : cfg.strap[`SBC_LOG_EDGE_BIT];
    assign cfg.out_rise = cfg.ovr_edge_en ? cfg.ovr_out_rise : cfg.strap[`SBC_OUT_EDGE_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ldo_map;
        @(posedge aclk) disable iff (!aresetn)
        !cfg.ovr_ldo_en |-> cfg.ldo_1v8 == cfg.strap[`SBC_LDO_BIT];
    endproperty
    a_ldo_map: assert property (p_ldo_map) else $error("supply level does not follow strap");

    property p_flash_boot;
        @(posedge aclk) disable iff (!aresetn)
        cfg.strap[`SBC_BOOT_SEL_BIT] |-> cfg.boot_mode == sbc_pkg::SBC_BOOT_FLASH;
    endproperty
    a_flash_boot: assert property (p_flash_boot) else $error("boot select high but not flash boot");

    property p_edge_map;
        @(posedge aclk) disable iff (!aresetn)
        !cfg.ovr_edge_en |-> (cfg.in_rise == cfg.strap[`SBC_LOG_EDGE_BIT])
            && (cfg.out_rise == cfg.strap[`SBC_OUT_EDGE_BIT]);
    endproperty
    a_edge_map: assert property (p_edge_map) else $error("slave edges do not follow straps");

    property p_override;
        @(posedge aclk) disable iff (!aresetn)
        (cfg.ovr_ldo_en && cfg.ovr_edge_en) |-> (cfg.ldo_1v8 == cfg.ovr_ldo_1v8)
            && (cfg.in_rise == cfg.ovr_in_rise) && (cfg.out_rise == cfg.ovr_out_rise);
    endproperty
    a_override: assert property (p_override) else $error("firmware override not applied");

endmodule // sbc_decode

// >>> hdl/sbc_pkg.sv
// Types shared by the strap boot configuration block.
package sbc_pkg;

    typedef logic [5:0] sbc_strap_type;

    typedef enum logic [1:0] {
        SBC_BOOT_FLASH,
        SBC_BOOT_DOWNLOAD,
        SBC_BOOT_UNDEFINED
    } sbc_boot_mode_type;

endpackage

// >>> hdl/sbc_regs.svh
// Register offsets, field positions and reset values of the strap boot configuration block.
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SBC_CAPTURE_OFS 8'h00
`define SBC_STATUS_OFS 8'h04
`define SBC_OVERRIDE_OFS 8'h08

// ----------------------------------------------------------------
// Strap bit positions
// ----------------------------------------------------------------
`define SBC_LDO_BIT 0
`define SBC_BOOT_SEL_BIT 1
`define SBC_DL_QUAL_BIT 2
`define SBC_LOG_EDGE_BIT 3
`define SBC_OUT_EDGE_BIT 4
`define SBC_SPARE_BIT 5

// ----------------------------------------------------------------
// Reset values and pull directions
// ----------------------------------------------------------------
`define SBC_STRAP_DEFAULT 6'h1a
`define SBC_PULL_UP_MASK 6'h1a
`define SBC_ALL_STRAPS 6'h3f
`define SBC_NO_STRAPS 6'h00
`define SBC_OVERRIDE_RESET 6'h00

// ----------------------------------------------------------------
// Override register fields
// ----------------------------------------------------------------
`define SBC_OVR_LDO_EN_BIT 0
`define SBC_OVR_LDO_1V8_BIT 1
`define SBC_OVR_EDGE_EN_BIT 2
`define SBC_OVR_IN_RISE_BIT 3
`define SBC_OVR_OUT_RISE_BIT 4
`define SBC_OVR_BOOT_DONE_BIT 5

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SBC_ST_LDO_1V8_BIT 0
`define SBC_ST_MODE_LSB 1
`define SBC_ST_LOG_EN_BIT 3
`define SBC_ST_IN_RISE_BIT 4
`define SBC_ST_OUT_RISE_BIT 5
`define SBC_ST_POR_BIT 6
`define SBC_ST_BOOTING_BIT 7

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define SBC_RESP_OKAY 2'h0
`define SBC_RESP_SLVERR 2'h2

`endif

// >>> hdl/sbc_top.sv
// Strap pin capture block with pull control, pin hand-back and an AXI4-Lite register port.
//
// Operation
// - While power-on reset is active each strap pin level is sampled as one configuration bit.
// - Captured strap bits stay unchanged until power-down, whatever the pins do later.
// - Exactly six strap bits are captured and all can be read from the strap capture register.
// - During reset every strap pin gets a weak pull; supply, qualifier and spare pull low, the rest pull high.
// - After reset the strap pins are handed back to their normal functional use.
// - Supply strap 0 selects the 3.3 V flash supply and 1 selects the 1.8 V supply.
// - Boot select 1 boots from serial flash; boot select 0 with qualifier 0 enters download boot.
// - Log strap 1 lets boot debug output reach the console transmit pin; 0 keeps it silent while booting.
// - The log strap sets the slave input sampling edge and the output-edge strap the launch edge.
// - Firmware bits may override supply and slave edges without altering the captured straps.
// - Chip enable is active high and the device stays in reset while it is low.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "sbc_regs.svh"
module sbc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_enable,
    input wire logic [5:0] strap_pin_in,
    output logic [5:0] strap_pin_out,
    output logic [5:0] strap_pin_oe_n,
    output logic [5:0] strap_pull_en,
    output logic [5:0] strap_pull_up,
    input wire logic [5:0] func_out,
    input wire logic [5:0] func_oe_n,
    output logic [5:0] func_in,
    input wire logic console_tx_data,
    output logic console_transmit_pin,
    output logic ldo_1v8,
    output logic [1:0] boot_mode,
    output logic slave_in_rise,
    output logic slave_out_rise,
    output logic in_reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------------------------------
    // Address decoding
    // ----------------------------------------------------------------
    function automatic logic sbc_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    function automatic logic sbc_mapped(input logic [7:0] addr);
        return sbc_hit(addr, `SBC_CAPTURE_OFS) || sbc_hit(addr, `SBC_STATUS_OFS)
            || sbc_hit(addr, `SBC_OVERRIDE_OFS);
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    sbc_cfg_if cfg ();

    logic ce_meta_reg;
    logic ce_sync_reg;
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic por_reg;
    sbc_pkg::sbc_strap_type strap_reg;
    logic [5:0] override_reg;
    logic [5:0] pin_out_reg;
    logic [5:0] pin_oe_n_reg;
    logic [5:0] pull_en_reg;
    logic tx_reg;
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    wire logic por_next;
    wire logic booting;
    wire logic aw_take;
    wire logic w_take;
    wire logic ar_take;
    wire logic do_write;
    wire logic write_ovr;
    wire logic [5:0] override_next;
    wire logic [31:0] status_word;
    wire logic [31:0] read_word;
    wire logic tx_next;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // The chip enable and strap pins come from the board, so each passes two flops.
    always_ff @(posedge aclk) begin
        ce_meta_reg <= chip_enable;
        ce_sync_reg <= ce_meta_reg;
        pin_meta_reg <= strap_pin_in;
        pin_sync_reg <= pin_meta_reg;
    end

    // ----------------------------------------------------------------
    // Power-on reset state and strap latches
    // ----------------------------------------------------------------
    assign por_next = !ce_sync_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_reg <= 1'b1;
        end else begin
            por_reg <= por_next;
        end
    end

    // While por_reg is high the latches follow the pins, and the edge that clears
    // por_reg still samples, so levels settled just before release are kept.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_reg <= `SBC_STRAP_DEFAULT;
        end else if (por_reg) begin
            strap_reg <= pin_sync_reg;
        end
    end

    // ----------------------------------------------------------------
    // Pull control and pin hand-back
    // ----------------------------------------------------------------
    // The pins are never driven during reset, so only the weak pulls set a floating level.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pull_en_reg <= `SBC_ALL_STRAPS;
            pin_oe_n_reg <= `SBC_ALL_STRAPS;
            pin_out_reg <= `SBC_NO_STRAPS;
        end else if (por_next) begin
            pull_en_reg <= `SBC_ALL_STRAPS;
            pin_oe_n_reg <= `SBC_ALL_STRAPS;
            pin_out_reg <= `SBC_NO_STRAPS;
        end else begin
            pull_en_reg <= `SBC_NO_STRAPS;
            pin_oe_n_reg <= func_oe_n;
            pin_out_reg <= func_out;
        end
    end

    assign strap_pull_en = pull_en_reg;
    assign strap_pull_up = `SBC_PULL_UP_MASK;
    assign strap_pin_oe_n = pin_oe_n_reg;
    assign strap_pin_out = pin_out_reg;
    assign func_in = pin_sync_reg;
    assign in_reset = por_reg;

    // ----------------------------------------------------------------
    // Console transmit gate
    // ----------------------------------------------------------------
    // Booting lasts from reset until firmware sets the boot-done bit; a silent
    // console holds the line at its idle high level rather than floating it.
    assign booting = !override_reg[`SBC_OVR_BOOT_DONE_BIT];
    assign tx_next = (booting && !cfg.log_enable) ? 1'b1 : console_tx_data;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_reg <= 1'b1;
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign console_transmit_pin = tx_reg;

    // ----------------------------------------------------------------
    // Decoder
    // ----------------------------------------------------------------
    assign cfg.strap = strap_reg;
    assign cfg.ovr_ldo_en = override_reg[`SBC_OVR_LDO_EN_BIT];
    assign cfg.ovr_ldo_1v8 = override_reg[`SBC_OVR_LDO_1V8_BIT];
    assign cfg.ovr_edge_en = override_reg[`SBC_OVR_EDGE_EN_BIT];
    assign cfg.ovr_in_rise = override_reg[`SBC_OVR_IN_RISE_BIT];
    assign cfg.ovr_out_rise = override_reg[`SBC_OVR_OUT_RISE_BIT];

    sbc_decode u_decode (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg.decoder)
    );

    assign ldo_1v8 = cfg.ldo_1v8;
    assign boot_mode = cfg.boot_mode;
    assign slave_in_rise = cfg.in_rise;
    assign slave_out_rise = cfg.out_rise;

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are held separately so they may arrive in either order.
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    assign write_ovr = do_write && sbc_hit(aw_addr_reg, `SBC_OVERRIDE_OFS) && w_strb_reg[0];
    assign override_next = w_data_reg[5:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (aw_take) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (w_take) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `SBC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= sbc_mapped(aw_addr_reg) ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // The capture register is read-only; only this register takes firmware writes,
    // so nothing on the bus can disturb the latched straps.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            override_reg <= `SBC_OVERRIDE_RESET;
        end else if (write_ovr) begin
            override_reg <= override_next;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign status_word = {
        24'h00_0000,
        booting,
        por_reg,
        cfg.out_rise,
        cfg.in_rise,
        cfg.log_enable,
        cfg.boot_mode,
        cfg.ldo_1v8
    };

    assign read_word = sbc_hit(s_axi_araddr, `SBC_CAPTURE_OFS) ? {26'h000_0000, strap_reg} :
        sbc_hit(s_axi_araddr, `SBC_STATUS_OFS) ? status_word :
        sbc_hit(s_axi_araddr, `SBC_OVERRIDE_OFS) ? {26'h000_0000, override_reg} :
        32'h0000_0000;

    assign s_axi_arready = !rvalid_reg;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SBC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= read_word;
            rresp_reg <= sbc_mapped(s_axi_araddr) ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_capture;
        @(posedge aclk) disable iff (!aresetn)
        por_reg |=> strap_reg == $past(pin_sync_reg);
    endproperty
    a_capture: assert property (p_capture) else $error("strap not sampled during reset");

    property p_release_sample;
        @(posedge aclk) disable iff (!aresetn)
        (por_reg && !por_next) |=> !por_reg && strap_reg == $past(pin_sync_reg);
    endproperty
    a_release_sample: assert property (p_release_sample) else $error("release edge missed sample");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        !por_reg |=> $stable(strap_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("strap latch changed after reset");

    sequence s_cap_req;
        ar_take && sbc_hit(s_axi_araddr, `SBC_CAPTURE_OFS);
    endsequence

    sequence s_cap_answer;
        ##1 rvalid_reg && rdata_reg == {26'h000_0000, $past(strap_reg)};
    endsequence

    property p_cap_read;
        @(posedge aclk) disable iff (!aresetn)
        s_cap_req |-> s_cap_answer;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capture register read wrong");

    property p_pulls;
        @(posedge aclk) disable iff (!aresetn)
        por_next |=> strap_pull_en == `SBC_ALL_STRAPS && strap_pin_oe_n == `SBC_ALL_STRAPS;
    endproperty
    a_pulls: assert property (p_pulls) else $error("pulls off or pin driven in reset");

    property p_handback;
        @(posedge aclk) disable iff (!aresetn)
        !por_next |=> strap_pull_en == `SBC_NO_STRAPS && strap_pin_oe_n == $past(func_oe_n)
            && strap_pin_out == $past(func_out);
    endproperty
    a_handback: assert property (p_handback) else $error("pins not returned to normal use");

    property p_silent;
        @(posedge aclk) disable iff (!aresetn)
        (booting && !cfg.log_enable) |=> console_transmit_pin;
    endproperty
    a_silent: assert property (p_silent) else $error("console not silent during boot");

    property p_ce_low;
        @(posedge aclk) disable iff (!aresetn)
        !ce_sync_reg |=> por_reg [*1] ##0 in_reset;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("chip enable low but out of reset");

endmodule // sbc_top

// >>> tb/sbc_board.sv
// Board model: weak pulls, host controller drive and floating strap pins.
`timescale 1ns/10ps
module sbc_board (
    input wire logic aclk,
    input wire logic [5:0] pull_en,
    input wire logic [5:0] pull_up,
    input wire logic [5:0] dev_out,
    input wire logic [5:0] dev_oe_n,
    input wire logic [5:0] host_val,
    input wire logic host_en,
    output logic [5:0] pin
);
    // A floating pin toggles so that a stale level can never look captured.
    logic [5:0] float_reg = 6'h15;

    always_ff @(posedge aclk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!dev_oe_n[i])
                pin[i] = dev_out[i];
            else if (host_en)
                pin[i] = host_val[i];
            else if (pull_en[i])
                pin[i] = pull_up[i];
            else
                pin[i] = float_reg[i];
        end
    end
endmodule // sbc_board

// >>> tb/testbench.sv
// Self-checking testbench of the strap boot configuration block.
`timescale 1ns/10ps
`include "sbc_regs.svh"
module testbench;
    logic aclk, aresetn, chip_enable, console_tx_data, console_transmit_pin, ldo_1v8, slave_in_rise, slave_out_rise;
    logic in_reset, host_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [5:0] strap_pin_in, strap_pin_out, strap_pin_oe_n, strap_pull_en, strap_pull_up, func_out, func_oe_n;
    logic [5:0] func_in, host_val;
    logic [1:0] boot_mode, s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [5:0] pat [5] = '{6'h00, 6'h25, 6'h1b, 6'h0a, 6'h12};
    int errors, checked;

    sbc_top DUT (.*);
    sbc_board board (.aclk(aclk), .pull_en(strap_pull_en), .pull_up(strap_pull_up), .dev_out(strap_pin_out),
        .dev_oe_n(strap_pin_oe_n), .host_val(host_val), .host_en(host_en), .pin(strap_pin_in));

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    task automatic complete_run;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        errors++;
        $display("mismatch at %0t: no answer on %s", $time, what);
        complete_run();
    endtask

    // Each bus task first lets an edge pass, so a ready lowered by the last call is never raised in the same step.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n == 20) hang("write");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n == 20) hang("read");
    endtask

    task automatic wait_reset(input logic lvl);
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (in_reset === lvl) break;
        end
        if (n == 20) hang("in_reset");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // The host keeps driving three cycles past release, as a board must.
    task automatic power_on(input logic [5:0] v, input logic drv);
        host_val <= v;
        host_en <= drv;
        chip_enable <= 1'h0;
        wait_reset(1'h1);
        @(posedge aclk);
        chk(strap_pull_en, 6'h3f, "pulls on");
        chk(strap_pull_up, 6'h1a, "pull direction");
        chk(strap_pin_oe_n, 6'h3f, "pins undriven");
        chk(strap_pin_out, 6'h00, "pin out in reset");
        repeat (4) @(posedge aclk);
        chip_enable <= 1'h1;
        wait_reset(1'h0);
        repeat (3) @(posedge aclk);
        host_en <= 1'h0;
        chk(strap_pull_en, 6'h00, "pulls off");
        chk(strap_pin_oe_n, 6'h3e, "pins handed back");
        chk(strap_pin_out, 6'h01, "pin out handed back");
    endtask

    task automatic check_straps(input logic [5:0] v);
        logic [1:0] m;
        m = v[1] ? 2'h0 : (v[2] ? 2'h2 : 2'h1);
        axi_read(`SBC_CAPTURE_OFS, rd, rsp);
        chk(rd, {26'h0, v}, "capture");
        chk(rsp, 2'h0, "capture resp");
        axi_read(`SBC_STATUS_OFS, rd, rsp);
        chk(rd, {25'h1, 1'h0, v[4], v[3], v[3], m, v[0]}, "status");
        chk(ldo_1v8, v[0], "supply");
        chk(boot_mode, m, "boot mode");
        chk(slave_in_rise, v[3], "input edge");
        chk(slave_out_rise, v[4], "output edge");
        chk(console_transmit_pin, !v[3], "console gate");
        chk(func_in[0], 1'h1, "pin function");
    endtask

    // Overrides move the settings only; the captured straps stay put.
    task automatic override_test;
        axi_write(`SBC_OVERRIDE_OFS, 32'h1f, rsp);
        chk(rsp, 2'h0, "override resp");
        axi_read(`SBC_OVERRIDE_OFS, rd, rsp);
        chk(rd, 32'h1f, "override readback");
        chk({ldo_1v8, slave_in_rise, slave_out_rise}, 3'h7, "override on");
        axi_write(`SBC_CAPTURE_OFS, 32'h3f, rsp);
        axi_read(`SBC_CAPTURE_OFS, rd, rsp);
        chk(rd, 32'h12, "capture kept");
        axi_write(`SBC_OVERRIDE_OFS, 32'h24, rsp);
        axi_read(8'h0c, rd, rsp);
        chk(rd, 32'h0, "unmapped data");
        chk(rsp, 2'h2, "unmapped resp");
        chk({ldo_1v8, slave_in_rise, slave_out_rise}, 3'h0, "override edges");
        chk(console_transmit_pin, 1'h0, "console after boot");
    endtask

    initial begin
        aresetn = 1'h0;
        chip_enable = 1'h0;
        console_tx_data = 1'h0;
        host_en = 1'h0;
        host_val = 6'h00;
        func_out = 6'h01;
        func_oe_n = 6'h3e;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        power_on(6'h00, 1'h0);
        check_straps(6'h1a);
        foreach (pat[i]) begin
            power_on(pat[i], 1'h1);
            check_straps(pat[i]);
        end
        override_test();
        complete_run();
    end
endmodule // testbench
